// file: hdl/lbs_pkg.sv
// Purpose: Shared constants and types of the logic bus sampler.
// Assumes: One acquisition sample per pclk cycle.
// Notes: Register offsets are byte addresses on APB.
package lbs_pkg;
    localparam int NUM_CH = 16;
    localparam int NUM_BUS = 4;
    localparam int LVL_W = 8;
    localparam int SKEW_W = 4;
    localparam int HIST_DEPTH = 32;
    localparam int IRQ_W = 5;
    localparam int IRQ_CONFLICT = 4;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_THR = 8'h04;
    localparam logic [7:0] OFF_SKEW_GLB = 8'h08;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFF_STATE = 8'h14;
    localparam logic [7:0] OFF_SKEW_LO = 8'h18;
    localparam logic [7:0] OFF_SKEW_HI = 8'h1C;
    localparam logic [7:0] OFF_BUS_CFG = 8'h40;
    localparam logic [7:0] OFF_BUS_THR = 8'h44;
    localparam logic [7:0] OFF_BUS_VAL = 8'h60;
    localparam int CFG_EN = 0;
    localparam int CFG_CLK = 1;
    localparam int CFG_RISE = 2;
    localparam int CFG_SRC_LSB = 4;
    localparam int CFG_FMT_LSB = 8;
    localparam int CFG_MASK_LSB = 16;
    localparam logic [31:0] CFG_WMASK = 32'hFFFF0FF7;
    localparam int CTRL_COUPLE = 0;
    localparam int CTRL_POD_LO = 1;
    localparam int CTRL_POD_HI = 2;
    localparam logic [2:0] CTRL_RST = 3'h7;
    localparam logic [7:0] THR_RST = 8'h80;
    localparam logic [3:0] FMT_SIGNED = 4'h5;
    localparam logic [7:0] BAND_NORMAL = 8'h02;
    localparam logic [7:0] BAND_MAX = 8'h10;
    localparam logic [7:0] BAND_ROB_RISE = 8'h0C;
    localparam logic [7:0] BAND_ROB_FALL = 8'h06;
    typedef enum logic [1:0] {
        HYST_NORMAL = 2'h0, HYST_MAX = 2'h1, HYST_ROBUST = 2'h2
    } hyst_e;
    typedef enum logic [1:0] {APB_IDLE = 2'b01, APB_ACC = 2'b10} apb_st_e;
    // Robust mode uses a wider band above than below the threshold.
    function automatic logic [7:0] band_up(input logic [1:0] m);
        return (m == HYST_MAX) ? BAND_MAX :
               (m == HYST_ROBUST) ? BAND_ROB_RISE : BAND_NORMAL; // [RULE5]
    endfunction
    function automatic logic [7:0] band_dn(input logic [1:0] m);
        return (m == HYST_MAX) ? BAND_MAX :
               (m == HYST_ROBUST) ? BAND_ROB_FALL : BAND_NORMAL; // [RULE5]
    endfunction
endpackage

// file: hdl/sample_if.sv
// Purpose: Channel samples between the core and its helper modules.
// Assumes: All members live in the pclk domain.
// Notes: None.
interface sample_if;
    logic [lbs_pkg::NUM_CH*lbs_pkg::LVL_W-1:0] level;
    logic [7:0] thr;
    logic [7:0] band_up;
    logic [7:0] band_dn;
    logic [lbs_pkg::NUM_CH-1:0] state;
    logic [lbs_pkg::NUM_CH-1:0] delayed;
    logic [lbs_pkg::NUM_CH*lbs_pkg::SKEW_W-1:0] ch_skew;
    logic [lbs_pkg::SKEW_W-1:0] glb_skew;
    modport cmp (input level, thr, band_up, band_dn, output state);
    modport skew (input state, ch_skew, glb_skew, output delayed);
    modport core (output level, thr, band_up, band_dn, ch_skew, glb_skew,
                  input state, delayed);
endinterface

// file: hdl/hyst_cmp.sv
// Purpose: Threshold comparators with hysteresis, one per channel.
// Assumes: Levels are already synchronised to pclk.
// Notes: Inside the band the previous state is held.
module hyst_cmp (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Samples
    sample_if.cmp sif
);
    logic [lbs_pkg::NUM_CH-1:0] state_r;
    wire logic [lbs_pkg::NUM_CH-1:0] state_nxt;
    for (genvar c = 0; c < lbs_pkg::NUM_CH; c++) begin : g_ch
        wire logic [8:0] lvl = {1'b0, sif.level[c*lbs_pkg::LVL_W +: 8]};
        wire logic hi = lvl > ({1'b0, sif.thr} + {1'b0, sif.band_up});
        wire logic lo = (lvl + {1'b0, sif.band_dn}) < {1'b0, sif.thr};
        assign state_nxt[c] = hi ? 1'b1 : (lo ? 1'b0 : state_r[c]); // [RULE1] [RULE2]
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end
    assign sif.state = state_r;
endmodule // hyst_cmp

// file: hdl/skew_line.sv
// Purpose: Sample history memory giving each channel its own delay.
// Assumes: Channel and common delays are at most 15 samples each.
// Notes: Zero delay still costs two samples of latency.
module skew_line (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Samples
    sample_if.skew sif
);
    localparam int D = lbs_pkg::HIST_DEPTH;
    logic [D-1:0][lbs_pkg::NUM_CH-1:0] hist_r;
    logic [lbs_pkg::NUM_CH-1:0] delayed_r;
    wire logic [lbs_pkg::NUM_CH-1:0] tap;
    for (genvar c = 0; c < lbs_pkg::NUM_CH; c++) begin : g_tap
        wire logic [4:0] idx = {1'b0, sif.ch_skew[c*4 +: 4]} +
                               {1'b0, sif.glb_skew}; // [RULE11] [RULE12]
        assign tap[c] = hist_r[idx][c];
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist_r <= '0;
            delayed_r <= '0;
        end else begin
            hist_r <= {hist_r[D-2:0], sif.state};
            delayed_r <= tap;
        end
    end
    assign sif.delayed = delayed_r;
endmodule // skew_line

// file: hdl/logic_bus_sampler.sv
// Purpose: Logic bus sampler for sixteen digital input channels.
// Assumes: pclk is the acquisition sample clock, one sample per cycle.
// Notes: Registers are reached over APB; one level interrupt output.
// Operation
// [RULE1] Input above threshold records one, below records zero, every sample.
// [RULE2] A hysteresis band keeps noise near threshold from toggling state.
// [RULE3] After reset coupling is on; all channels share one threshold.
// [RULE4] Enabled buses use the threshold of the last bus enabled.
// [RULE5] Hysteresis is normal, maximum, or robust with separate rise/fall bands.
// [RULE6] An unclocked bus takes a new value on every sample.
// [RULE7] A clocked bus captures only on the chosen clock channel edge.
// [RULE8] A per-bus selector picks which channel is the bus clock.
// [RULE9] Clocked buses emit one word with timestamp per qualifying edge.
// [RULE10] Bus words are at most sixteen bits, signed as two's complement.
// [RULE11] Each channel has its own programmable delay.
// [RULE12] One common delay shifts all channels together.
// [RULE13] One control enables each pod of eight channels at once.
// [RULE14] Binary output is signed only for the signed format.
// [RULE15] Enabling a bus sharing a channel disables the older one, flags it.
// [RULE16] Up to four independent logic buses.
// [RULE17] Everything runs on the sample clock; bus setup changes only disabled.
module logic_bus_sampler (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Comparator levels of the digital input channels, from pins
    input wire logic [127:0] digital_input_channels,
    // Bus values and decoded entries
    output logic [63:0] bus_word,
    output logic [3:0] res_valid,
    output logic [63:0] res_word,
    output logic [3:0] res_signed,
    output logic [31:0] res_time,
    // Interrupt
    output logic irq
);
    localparam int NB = lbs_pkg::NUM_BUS;
    sample_if sif ();
    logic [127:0] lvl_s1_r;
    logic [127:0] lvl_s2_r;
    logic [2:0] ctrl_r;
    logic [9:0] gthr_r;
    logic [9:0] act_thr_r;
    logic [3:0] gskew_r;
    logic [63:0] skew_r;
    logic [NB-1:0][31:0] cfg_r;
    logic [NB-1:0][9:0] bthr_r;
    logic [NB-1:0][15:0] word_r;
    logic [NB-1:0][15:0] res_word_r;
    logic [NB-1:0] res_valid_r;
    logic [NB-1:0] res_signed_r;
    logic [31:0] res_time_r;
    logic [31:0] ts_r;
    logic [15:0] prev_r;
    logic [lbs_pkg::IRQ_W-1:0] stat_r;
    logic [lbs_pkg::IRQ_W-1:0] mask_r;
    logic irq_r;
    lbs_pkg::apb_st_e st_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [31:0] rd_nxt;
    logic mapped;

    function automatic logic is_cfg(input logic [7:0] a);
        return a[7:5] == lbs_pkg::OFF_BUS_CFG[7:5] &&
               a[2:0] == lbs_pkg::OFF_BUS_CFG[2:0];
    endfunction
    function automatic logic is_thr(input logic [7:0] a);
        return a[7:5] == lbs_pkg::OFF_BUS_THR[7:5] &&
               a[2:0] == lbs_pkg::OFF_BUS_THR[2:0];
    endfunction
    function automatic logic is_val(input logic [7:0] a);
        return a[7:4] == lbs_pkg::OFF_BUS_VAL[7:4] && a[1:0] == 2'h0;
    endfunction

    hyst_cmp u_cmp (.pclk(pclk), .presetn(presetn), .sif(sif));
    skew_line u_skew (.pclk(pclk), .presetn(presetn), .sif(sif));

    // Threshold used by all channels.
    wire logic couple = ctrl_r[lbs_pkg::CTRL_COUPLE];
    wire logic [9:0] eff_thr = couple ? gthr_r : act_thr_r; // [RULE3] [RULE4]
    assign sif.level = lvl_s2_r;
    assign sif.thr = eff_thr[7:0];
    assign sif.band_up = lbs_pkg::band_up(eff_thr[9:8]); // [RULE5]
    assign sif.band_dn = lbs_pkg::band_dn(eff_thr[9:8]); // [RULE5]
    assign sif.ch_skew = skew_r;
    assign sif.glb_skew = gskew_r;

    wire logic [15:0] pod_mask = {{8{ctrl_r[lbs_pkg::CTRL_POD_HI]}},
                                  {8{ctrl_r[lbs_pkg::CTRL_POD_LO]}}};
    wire logic [15:0] gated = sif.delayed & pod_mask; // [RULE13]

    // APB decode; a write lands at the edge that samples pready high.
    wire logic [1:0] bsel = paddr[4:3];
    wire logic [1:0] vsel = paddr[3:2];
    wire logic apb_wr = (st_r == lbs_pkg::APB_ACC) && psel && penable &&
                        pwrite && !pslverr_r;
    wire logic wr_any_cfg = apb_wr && is_cfg(paddr);
    wire logic [NB-1:0] en;
    wire logic [NB-1:0] wr_cfg;
    wire logic [NB-1:0] kill;
    wire logic [NB-1:0] edge_w;
    wire logic [NB-1:0] evt;
    wire logic any_en = |en;
    wire logic new_en = wr_any_cfg && pwdata[lbs_pkg::CFG_EN] && !en[bsel];
    wire logic glb_wr_ok = apb_wr && !any_en; // [RULE17]
    wire logic [lbs_pkg::IRQ_W-1:0] stat_clr =
        (apb_wr && paddr == lbs_pkg::OFF_IRQ_STAT) ?
        pwdata[lbs_pkg::IRQ_W-1:0] : '0;
    wire logic [lbs_pkg::IRQ_W-1:0] stat_set = {|kill, evt};

    always_comb begin
        rd_nxt = '0;
        mapped = 1'b1;
        if (is_cfg(paddr)) begin
            rd_nxt = cfg_r[bsel];
        end else if (is_thr(paddr)) begin
            rd_nxt = {22'h000000, bthr_r[bsel]};
        end else if (is_val(paddr)) begin
            rd_nxt = {16'h0000, word_r[vsel]};
        end else begin
            case (paddr)
                lbs_pkg::OFF_CTRL: rd_nxt = {29'h00000000, ctrl_r};
                lbs_pkg::OFF_THR: rd_nxt = {22'h000000, gthr_r};
                lbs_pkg::OFF_SKEW_GLB: rd_nxt = {28'h0000000, gskew_r};
                lbs_pkg::OFF_IRQ_STAT: rd_nxt = {27'h0000000, stat_r};
                lbs_pkg::OFF_IRQ_MASK: rd_nxt = {27'h0000000, mask_r};
                lbs_pkg::OFF_STATE: rd_nxt = {16'h0000, gated};
                lbs_pkg::OFF_SKEW_LO: rd_nxt = skew_r[31:0];
                lbs_pkg::OFF_SKEW_HI: rd_nxt = skew_r[63:32];
                default: mapped = 1'b0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= lbs_pkg::APB_IDLE;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end else begin
            case (st_r)
                lbs_pkg::APB_IDLE: begin
                    if (psel && penable) begin
                        st_r <= lbs_pkg::APB_ACC;
                        pready_r <= 1'b1;
                        pslverr_r <= !mapped;
                        prdata_r <= pwrite ? 32'h00000000 : rd_nxt;
                    end
                end
                lbs_pkg::APB_ACC: begin
                    st_r <= lbs_pkg::APB_IDLE;
                    pready_r <= 1'b0;
                    pslverr_r <= 1'b0;
                end
                default: begin
                    st_r <= lbs_pkg::APB_IDLE;
                    pready_r <= 1'b0;
                    pslverr_r <= 1'b0;
                end
            endcase
        end
    end

    // Global settings; threshold and skew are frozen while a bus runs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= lbs_pkg::CTRL_RST; // [RULE3]
            gthr_r <= {lbs_pkg::HYST_NORMAL, lbs_pkg::THR_RST};
            act_thr_r <= {lbs_pkg::HYST_NORMAL, lbs_pkg::THR_RST};
            gskew_r <= '0;
            skew_r <= '0;
            mask_r <= '0;
        end else begin
            if (apb_wr && paddr == lbs_pkg::OFF_CTRL) begin
                ctrl_r <= pwdata[2:0]; // [RULE13]
            end
            if (glb_wr_ok && paddr == lbs_pkg::OFF_THR) begin
                gthr_r <= pwdata[9:0];
            end
            if (glb_wr_ok && paddr == lbs_pkg::OFF_SKEW_GLB) begin
                gskew_r <= pwdata[3:0]; // [RULE12]
            end
            if (glb_wr_ok && paddr == lbs_pkg::OFF_SKEW_LO) begin
                skew_r[31:0] <= pwdata; // [RULE11]
            end
            if (glb_wr_ok && paddr == lbs_pkg::OFF_SKEW_HI) begin
                skew_r[63:32] <= pwdata; // [RULE11]
            end
            if (apb_wr && paddr == lbs_pkg::OFF_IRQ_MASK) begin
                mask_r <= pwdata[lbs_pkg::IRQ_W-1:0];
            end
            if (new_en) begin
                act_thr_r <= bthr_r[bsel]; // [RULE4]
            end
        end
    end

    // Per-bus configuration, capture and decoded entries.
    for (genvar b = 0; b < NB; b++) begin : g_bus // [RULE16]
        wire logic [3:0] src = cfg_r[b][lbs_pkg::CFG_SRC_LSB +: 4];
        wire logic cur = gated[src]; // [RULE8]
        wire logic prv = prev_r[src];
        wire logic clocked = cfg_r[b][lbs_pkg::CFG_CLK];
        wire logic [15:0] bmask = cfg_r[b][lbs_pkg::CFG_MASK_LSB +: 16];
        wire logic [3:0] fmt = cfg_r[b][lbs_pkg::CFG_FMT_LSB +: 4];
        wire logic upd = en[b] && (!clocked || edge_w[b]); // [RULE6] [RULE7]
        assign en[b] = cfg_r[b][lbs_pkg::CFG_EN];
        assign wr_cfg[b] = wr_any_cfg && bsel == 2'(b);
        assign edge_w[b] = cfg_r[b][lbs_pkg::CFG_RISE] ?
                           (cur && !prv) : (!cur && prv); // [RULE7]
        assign evt[b] = en[b] && clocked && edge_w[b]; // [RULE9]
        assign kill[b] = new_en && en[b] && !wr_cfg[b] &&
                         |(pwdata[31:16] & bmask); // [RULE15]
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cfg_r[b] <= '0;
                bthr_r[b] <= {lbs_pkg::HYST_NORMAL, lbs_pkg::THR_RST};
                word_r[b] <= '0;
                res_word_r[b] <= '0;
                res_valid_r[b] <= 1'b0;
                res_signed_r[b] <= 1'b0;
            end else begin
                if (kill[b]) begin
                    cfg_r[b][lbs_pkg::CFG_EN] <= 1'b0; // [RULE15]
                end else if (wr_cfg[b] && en[b]) begin
                    cfg_r[b][lbs_pkg::CFG_EN] <= pwdata[lbs_pkg::CFG_EN]; // [RULE17]
                end else if (wr_cfg[b]) begin
                    cfg_r[b] <= pwdata & lbs_pkg::CFG_WMASK;
                end
                if (apb_wr && is_thr(paddr) && bsel == 2'(b) && !en[b]) begin
                    bthr_r[b] <= pwdata[9:0]; // [RULE4] [RULE17]
                end
                if (upd) begin
                    word_r[b] <= gated & bmask; // [RULE6] [RULE10]
                end
                res_valid_r[b] <= evt[b]; // [RULE9]
                if (evt[b]) begin
                    res_word_r[b] <= gated & bmask;
                    res_signed_r[b] <= fmt == lbs_pkg::FMT_SIGNED; // [RULE14]
                end
            end
        end
    end

    // Sticky status: a new event wins over a clear in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_s1_r <= '0;
            lvl_s2_r <= '0;
            prev_r <= '0;
            ts_r <= '0;
            res_time_r <= '0;
            stat_r <= '0;
            irq_r <= 1'b0;
        end else begin
            lvl_s1_r <= digital_input_channels; // [RULE17]
            lvl_s2_r <= lvl_s1_r;
            prev_r <= gated;
            ts_r <= ts_r + 32'h00000001;
            if (|evt) begin
                res_time_r <= ts_r; // [RULE9]
            end
            stat_r <= (stat_r & ~stat_clr) | stat_set;
            irq_r <= |(stat_r & mask_r);
        end
    end

    assign pready = pready_r;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign bus_word = word_r;
    assign res_valid = res_valid_r;
    assign res_word = res_word_r;
    assign res_signed = res_signed_r;
    assign res_time = res_time_r;
    assign irq = irq_r;

    // Checks on channel 0 and bus 0, plus the active threshold taken from the bus being enabled.
    wire logic [8:0] lvl0 = {1'b0, lvl_s2_r[7:0]};
    wire logic hi0 = lvl0 > ({1'b0, sif.thr} + {1'b0, sif.band_up});
    wire logic lo0 = (lvl0 + {1'b0, sif.band_dn}) < {1'b0, sif.thr};
    wire logic zero_skew0 = skew_r[3:0] == 4'h0 && gskew_r == 4'h0;
    sequence s_qual0;
        en[0] && cfg_r[0][lbs_pkg::CFG_CLK] && edge_w[0];
    endsequence
    sequence s_entry0;
        res_valid_r[0] && res_time_r == $past(ts_r);
    endsequence
    property p_rise0;
        @(posedge pclk) disable iff (!presetn) hi0 |=> sif.state[0];
    endproperty
    a_rise0: assert property (p_rise0) // [RULE1]
        else $error("Channel 0 not one above threshold.");
    property p_band0;
        @(posedge pclk) disable iff (!presetn)
        (!hi0 && !lo0) |=> sif.state[0] == $past(sif.state[0]);
    endproperty
    a_band0: assert property (p_band0) // [RULE2]
        else $error("Channel 0 toggled inside the band.");
    property p_unclk0;
        @(posedge pclk) disable iff (!presetn)
        (en[0] && !cfg_r[0][lbs_pkg::CFG_CLK])
        |=> word_r[0] == $past(gated & cfg_r[0][31:16]);
    endproperty
    a_unclk0: assert property (p_unclk0) // [RULE6]
        else $error("Unclocked bus 0 missed a sample.");
    property p_hold0;
        @(posedge pclk) disable iff (!presetn)
        (en[0] && cfg_r[0][lbs_pkg::CFG_CLK] && !edge_w[0])
        |=> $stable(word_r[0]);
    endproperty
    a_hold0: assert property (p_hold0) // [RULE7]
        else $error("Clocked bus 0 changed without an edge.");
    property p_entry0;
        @(posedge pclk) disable iff (!presetn) s_qual0 |=> s_entry0;
    endproperty
    a_entry0: assert property (p_entry0) // [RULE9]
        else $error("Clock edge gave no decoded entry.");
    property p_kill0;
        @(posedge pclk) disable iff (!presetn)
        kill[0] |=> !en[0] && stat_r[lbs_pkg::IRQ_CONFLICT];
    endproperty
    a_kill0: assert property (p_kill0) // [RULE15]
        else $error("Conflicting bus 0 not disabled and flagged.");
    property p_pod0;
        @(posedge pclk) disable iff (!presetn)
        (!ctrl_r[lbs_pkg::CTRL_POD_LO] && en[0] && !cfg_r[0][1])
        |=> word_r[0][7:0] == 8'h00;
    endproperty
    a_pod0: assert property (p_pod0) // [RULE13]
        else $error("Disabled pod leaked into bus 0.");
    property p_frozen0;
        @(posedge pclk) disable iff (!presetn)
        (wr_cfg[0] && en[0]) |=> cfg_r[0][31:1] == $past(cfg_r[0][31:1]);
    endproperty
    a_frozen0: assert property (p_frozen0) // [RULE17]
        else $error("Enabled bus 0 setup was changed.");
    property p_act;
        @(posedge pclk) disable iff (!presetn)
        new_en |=> act_thr_r == $past(bthr_r[bsel]);
    endproperty
    a_act: assert property (p_act) // [RULE4]
        else $error("Last enabled bus threshold not taken.");
    property p_skew0;
        @(posedge pclk) disable iff (!presetn)
        zero_skew0 [*3] |-> sif.delayed[0] == $past(sif.state[0], 2);
    endproperty
    a_skew0: assert property (p_skew0) // [RULE11]
        else $error("Channel 0 delay wrong at zero skew.");
endmodule // logic_bus_sampler

// file: bench/dut_signals.sv
// Purpose: Probed device model driving the comparator levels.
// Assumes: Levels change just after a rising pclk edge.
// Notes: A near bit parks the level inside the normal band.
module dut_signals (
    // Clock
    input wire logic pclk,
    // Logic values asked for by the bench
    input wire logic [15:0] pattern,
    input wire logic [15:0] near,
    // Levels to the block
    output logic [127:0] levels
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge pclk) begin
        for (int c = 0; c < 16; c++) begin
            levels[8*c +: 8] <= near[c] ? 8'h81 :
                                (pattern[c] ? 8'hC0 : 8'h40);
        end
    end
endmodule // dut_signals

// file: bench/testbench.sv
// Purpose: Self-checking bench of the logic bus sampler over APB.
// Assumes: One sample per pclk cycle, 200 MHz.
// Notes: Waits of ten cycles cover the pin-to-bus pipeline.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err_s;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, res_time;
    logic [127:0] levels;
    logic [63:0] bus_word, res_word;
    logic [3:0] res_valid, res_signed;
    logic [15:0] pattern, near, last_word;
    logic [31:0] t_last, t_gap;
    int err_total, tests_run, n_ent;
    dut_signals i_sig (.pclk(pclk), .pattern(pattern), .near(near),
                       .levels(levels));
    logic_bus_sampler i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .digital_input_channels(levels), .bus_word(bus_word),
        .res_valid(res_valid), .res_word(res_word),
        .res_signed(res_signed), .res_time(res_time), .irq(irq));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (res_valid[0] === 1'b1) begin
            n_ent <= n_ent + 1;
            last_word <= res_word[15:0];
            t_gap <= res_time - t_last;
            t_last <= res_time;
        end
    end
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // The answer is taken at the rising edge that samples pready high,
    // and only then is the request released.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) chk(32'h1, 32'h0);
        q = prdata;
        err_s = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask
    initial begin
        #50us;
        err_total++;
        wrap_up();
    end
    initial begin
        logic r;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pattern = 16'h0000;
        near = 16'h0000;
        n_ent = 0;
        idle(20);
        presetn <= 1'b1;
        rd(lbs_pkg::OFF_CTRL, 32'h00000007);
        rd(lbs_pkg::OFF_THR, 32'h00000080);
        rd(lbs_pkg::OFF_BUS_THR, 32'h00000080);
        rd(8'h30, 32'h0);
        chk({31'h0, err_s}, 32'h1);
        $display("reset test done");
        pattern <= 16'hA5C3;
        idle(10);
        rd(lbs_pkg::OFF_STATE, 32'h0000A5C3);
        near <= 16'hFFFF;
        pattern <= 16'h0000;
        idle(10);
        rd(lbs_pkg::OFF_STATE, 32'h0000A5C3);
        near <= 16'h0000;
        idle(10);
        rd(lbs_pkg::OFF_STATE, 32'h00000000);
        $display("threshold test done");
        pattern <= 16'h3C96;
        wr(lbs_pkg::OFF_BUS_CFG, 32'h00FF0001);
        idle(10);
        rd(lbs_pkg::OFF_BUS_VAL, 32'h00000096);
        chk({16'h0, bus_word[15:0]}, 32'h00000096);
        wr(lbs_pkg::OFF_IRQ_MASK, 32'h00000014);
        wr(lbs_pkg::OFF_BUS_CFG + 8'h08, 32'h0F010001);
        idle(3);
        chk({31'h0, irq}, 32'h1);
        rd(lbs_pkg::OFF_BUS_CFG, 32'h00FF0000);
        wr(lbs_pkg::OFF_IRQ_STAT, 32'h00000010);
        idle(3);
        chk({31'h0, irq}, 32'h0);
        wr(lbs_pkg::OFF_BUS_CFG + 8'h08, 32'h0);
        $display("conflict test done");
        // Bus 0: rising edges with signed format, then falling with hex.
        for (int k = 1; k >= 0; k--) begin
            r = k[0];
            wr(lbs_pkg::OFF_BUS_CFG, 32'h0);
            pattern <= {15'h0, ~r};
            idle(10);
            wr(lbs_pkg::OFF_BUS_CFG,
               32'hFFFF0003 | {29'h0, r, 2'h0} | (r ? 32'h500 : 32'h0));
            n_ent = 0;
            for (int s = 0; s < 3; s++) begin
                pattern <= {8'h5A + s[7:0], 7'h0, ~r};
                idle(10);
                pattern <= {8'h5A + s[7:0], 7'h0, r};
                idle(10);
            end
            chk(n_ent, 32'd3);
            chk({16'h0, last_word}, {16'h0, 8'h5C, 7'h0, r});
            chk(t_gap, 32'd20);
            chk({31'h0, res_signed[0]}, {31'h0, r});
            rd(lbs_pkg::OFF_IRQ_STAT, 32'h00000001);
            wr(lbs_pkg::OFF_IRQ_STAT, 32'h00000001);
        end
        wr(lbs_pkg::OFF_BUS_CFG, 32'h0);
        $display("clocked bus test done");
        pattern <= 16'hFFFF;
        wr(lbs_pkg::OFF_BUS_CFG, 32'h00FF0001);
        wr(lbs_pkg::OFF_CTRL, 32'h00000003);
        idle(10);
        rd(lbs_pkg::OFF_STATE, 32'h000000FF);
        rd(lbs_pkg::OFF_BUS_VAL, 32'h000000FF);
        wr(lbs_pkg::OFF_CTRL, 32'h00000005);
        idle(10);
        rd(lbs_pkg::OFF_STATE, 32'h0000FF00);
        rd(lbs_pkg::OFF_BUS_VAL, 32'h00000000);
        wr(lbs_pkg::OFF_BUS_CFG, 32'h00000002);
        rd(lbs_pkg::OFF_BUS_CFG, 32'h00FF0000);
        $display("pod test done");
        wrap_up();
    end
endmodule // testbench
